// ---- fcd_defs.vh ----
// Constants for the four-character display store and control block.
`ifndef FCD_DEFS_VH
`define FCD_DEFS_VH
`define FCD_LOCS 4
`define FCD_AW 2
`define FCD_DW 7
`define FCD_SEGW 16
`define FCD_BLANK_CHAR 7'h20
`define FCD_SEG_ALL 16'hffff
`define FCD_SEG_OFF 16'h0000
`define FCD_CLK_MHZ 100
`define FCD_REFRESH_NS 20000
`define FCD_REFRESH_CYC ((`FCD_REFRESH_NS * `FCD_CLK_MHZ) / 1000)
`define FCD_DIV_W 12
`define FCD_LAST_LOC 2'h3
`define FCD_FIRST_LOC 2'h0
`define FCD_LOC_STEP 2'h1
`define FCD_DIV_LAST (`FCD_REFRESH_CYC - 1)
`define FCD_CURSOR_BIT 0
`define FCD_PIN_W 16
`define FCD_PIN_IDLE 16'hffff
`define FCD_PIN_SEL1 15
`define FCD_PIN_SEL2 14
`define FCD_PIN_STROBE 13
`define FCD_PIN_TGT 12
`define FCD_PIN_LOC_HI 11
`define FCD_PIN_LOC_LO 10
`define FCD_PIN_DAT_HI 9
`define FCD_PIN_DAT_LO 3
`define FCD_PIN_WIPE 2
`define FCD_PIN_CVIEW 1
`define FCD_PIN_DARK 0
`endif

// ---- fcd_store_ctrl.v ----
// Character store, cursor store, clear sweep and display drive of a four-character display.
`timescale 1ns/10ps
`include "fcd_defs.vh"
module fcd_store_ctrl (
	// Clock and reset
	input wire clk_sys,
	input wire rst_n,
	// Host write port, asynchronous pins
	input wire select_low_first_n,
	input wire select_low_second_n,
	input wire write_strobe_n,
	input wire mem_target_sel,
	input wire loc_bit_low,
	input wire loc_bit_high,
	input wire [`FCD_DW-1:0] data_in,
	// Display control pins
	input wire wipe_chars_n,
	input wire cursor_view_sel,
	input wire dark_n,
	// Display drive, rightmost position is digit 0
	output reg [`FCD_AW-1:0] digit_sel_r,
	output reg [`FCD_DW-1:0] digit_code_r,
	output reg digit_all_on_r,
	output reg digit_enable_r,
	output reg clear_busy_r
);

	// ********************
	// Reset and synchronisers
	// ********************
	// Reset asserts at once and releases two clocks after rst_n rises, away from any edge race.
	reg rst_s1_r;
	reg rst_s2_r;
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_r <= 1'h0;
			rst_s2_r <= 1'h0;
		end else begin
			rst_s1_r <= 1'h1;
			rst_s2_r <= rst_s1_r;
		end
	end

	// Pins are sampled twice; strobe and all qualifiers travel together so they stay aligned.
	wire [`FCD_PIN_W-1:0] pins_raw = {select_low_first_n, select_low_second_n, write_strobe_n, mem_target_sel,
		loc_bit_high, loc_bit_low, data_in, wipe_chars_n, cursor_view_sel, dark_n};
	reg [`FCD_PIN_W-1:0] pins_s1_r;
	reg [`FCD_PIN_W-1:0] pins_s2_r;
	reg [`FCD_PIN_W-1:0] pins_d_r;
	always @(posedge clk_sys or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			pins_s1_r <= `FCD_PIN_IDLE;
			pins_s2_r <= `FCD_PIN_IDLE;
			pins_d_r <= `FCD_PIN_IDLE;
		end else begin
			pins_s1_r <= pins_raw;
			pins_s2_r <= pins_s1_r;
			pins_d_r <= pins_s2_r;
		end
	end

	// ********************
	// Pin decode
	// ********************
	wire wr_n = pins_s2_r[`FCD_PIN_STROBE];
	wire wr_n_d = pins_d_r[`FCD_PIN_STROBE];
	// Qualifiers taken one sample before the rise, still inside the strobe.
	// Data must therefore settle about one clock before the strobe rises, the price of sampling pins.
	wire ce1_n_d = pins_d_r[`FCD_PIN_SEL1];
	wire ce2_n_d = pins_d_r[`FCD_PIN_SEL2];
	wire tgt_d = pins_d_r[`FCD_PIN_TGT];
	wire [`FCD_AW-1:0] loc_d = pins_d_r[`FCD_PIN_LOC_HI:`FCD_PIN_LOC_LO];
	wire [`FCD_DW-1:0] dat_d = pins_d_r[`FCD_PIN_DAT_HI:`FCD_PIN_DAT_LO];
	wire wipe_n = pins_s2_r[`FCD_PIN_WIPE];
	wire cview = pins_s2_r[`FCD_PIN_CVIEW];
	wire lit = pins_s2_r[`FCD_PIN_DARK];

	// ********************
	// Helpers
	// ********************
	// Next location in scan and sweep order.
	// It wraps from the leftmost position back to the rightmost one.
	function [`FCD_AW-1:0] fcd_loc_next;
		input [`FCD_AW-1:0] loc;
		begin
			fcd_loc_next = loc + `FCD_LOC_STEP;
		end
	endfunction

	// ********************
	// Storage and refresh timing
	// ********************
	// Both memories are plain flip-flops indexed by location.
	reg [`FCD_DW-1:0] char_mem_r [0:`FCD_LOCS-1];
	reg [`FCD_LOCS-1:0] cursor_mem_r;
	reg [`FCD_AW-1:0] sweep_loc_r;
	reg [`FCD_DIV_W-1:0] div_r;
	// Loop index for the reset of the character array only.
	integer i;
	wire tick = (div_r == `FCD_DIV_LAST);
	wire clear_go = ~wipe_n & lit;
	wire sweep_wr = clear_busy_r & tick & lit;

	// ********************
	// Write port
	// ********************
	// A write is taken on the strobe's rising edge from values held while it was low.
	wire wr_rise = wr_n & ~wr_n_d;
	wire wr_take = wr_rise & ~ce1_n_d & ~ce2_n_d;
	wire wr_char = wr_take & tgt_d;
	wire wr_cursor = wr_take & ~tgt_d;

	// The sweep and a host write may land together; only a write to the swept location overrides the blank.
	always @(posedge clk_sys or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			for (i = 0; i < `FCD_LOCS; i = i + 1) begin
				char_mem_r[i] <= `FCD_BLANK_CHAR;
			end
		end else begin
			if (sweep_wr) begin
				char_mem_r[sweep_loc_r] <= `FCD_BLANK_CHAR;
			end
			if (wr_char) begin
				char_mem_r[loc_d] <= dat_d;
			end
		end
	end

	// Cursor memory has its own process, so the clear sweep can never reach it.
	always @(posedge clk_sys or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			cursor_mem_r <= {`FCD_LOCS{1'h0}};
		end else if (wr_cursor) begin
			cursor_mem_r[loc_d] <= dat_d[`FCD_CURSOR_BIT];
		end
	end

	// ********************
	// Refresh divider and scan
	// ********************
	// Refresh counter is frozen while dark; memories are not touched.
	always @(posedge clk_sys or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			div_r <= {`FCD_DIV_W{1'h0}};
			digit_sel_r <= `FCD_FIRST_LOC;
		end else if (lit) begin
			if (tick) begin
				div_r <= {`FCD_DIV_W{1'h0}};
				digit_sel_r <= fcd_loc_next(digit_sel_r);
			end else begin
				div_r <= div_r + 1'h1;
			end
		end
	end

	// ********************
	// Clear sweep
	// ********************
	// One location is blanked per refresh tick; a request still held at the end starts a new pass.
	always @(posedge clk_sys or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			sweep_loc_r <= `FCD_FIRST_LOC;
			clear_busy_r <= 1'h0;
		end else if (lit && tick) begin
			if (clear_busy_r) begin
				sweep_loc_r <= fcd_loc_next(sweep_loc_r);
				if (sweep_loc_r == `FCD_LAST_LOC) begin
					clear_busy_r <= clear_go;
				end
			end else if (clear_go) begin
				clear_busy_r <= 1'h1;
				sweep_loc_r <= `FCD_FIRST_LOC;
			end
		end
	end

	// ********************
	// Display drive
	// ********************
	// Code and cursor flag lag the scan position by one clock.
	always @(posedge clk_sys or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			digit_code_r <= `FCD_BLANK_CHAR;
			digit_all_on_r <= 1'h0;
		end else begin
			digit_code_r <= char_mem_r[digit_sel_r];
			digit_all_on_r <= cview & cursor_mem_r[digit_sel_r];
		end
	end

	// Segment drive follows the synchronised dark pin, so going dark costs a few clocks.
	always @(posedge clk_sys or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			digit_enable_r <= 1'h0;
		end else begin
			digit_enable_r <= lit;
		end
	end
endmodule // fcd_store_ctrl

// ---- fcd_store_ctrl_asserts.sv ----
// Assertions on the display store and control block.
`timescale 1ns/10ps
module fcd_store_ctrl_asserts(
	// Clock, reset, controls
	input logic clk_sys,
	input logic rst_n,
	input logic cursor_view_sel,
	input logic dark_n,
	// Display drive
	input logic [1:0] digit_sel_r,
	input logic digit_all_on_r,
	input logic digit_enable_r,
	input logic clear_busy_r
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Six cycles covers the two-flop input sync plus the output register.
	sequence dark_held; !dark_n[*6]; endsequence
	sequence step; $changed(digit_sel_r); endsequence
	AST_DARK: assert property (dark_held |-> !digit_enable_r) else $error("lit in dark");
	AST_LIT: assert property (dark_n[*8] |-> digit_enable_r) else $error("dark when lit");
	AST_HALT: assert property (dark_held |=> $stable(digit_sel_r)) else $error("scan ran");
	AST_NOWIPE: assert property (dark_held |-> !$rose(clear_busy_r)) else $error("wiped");
	AST_CHAR: assert property (!cursor_view_sel[*6] |-> !digit_all_on_r) else $error("cursor");
	AST_ORDER: assert property (step |-> digit_sel_r == $past(digit_sel_r) + 2'h1) else $error("order");
	AST_PACE: assert property (step |=> $stable(digit_sel_r)[*8]) else $error("pace");
	AST_SPAN: assert property ($rose(clear_busy_r) |=> clear_busy_r[*8]) else $error("short");
endmodule // fcd_store_ctrl_asserts
bind fcd_store_ctrl fcd_store_ctrl_asserts fcd_store_ctrl_asserts_i(.clk_sys, .rst_n, .cursor_view_sel,
	.dark_n, .digit_sel_r, .digit_all_on_r, .digit_enable_r, .clear_busy_r);

// ---- fcd_host_model.sv ----
// Host bus model that writes the display store.
`timescale 1ns/10ps
module fcd_host_model(
	input wire logic clk,
	// Write pins
	output logic [12:0] pins
);
	initial pins = 13'h1fff;
	// Pins: both selects, strobe, target, two address bits, data.
	task wr(input logic t, input logic [1:0] a, input logic [6:0] v, input logic c2);
		@(negedge clk) pins = {1'b0, c2, 1'b1, t, a, v};
		@(negedge clk) pins[10] = 1'b0;
		repeat (2) @(negedge clk);
		pins[10] = 1'b1;
		repeat (4) @(negedge clk);
		// Released lines show the inverse so stale values cannot pass.
		pins = ~{2'h0, 1'b0, t, a, v};
	endtask
endmodule // fcd_host_model

// ---- tb_top.sv ----
// Self-checking bench for the display store and control block.
`timescale 1ns/10ps
`include "fcd_defs.vh"
module tb_top;
	logic clk_sys = 0, rst_n = 0, wipe_chars_n = 1, cursor_view_sel = 0, dark_n = 1;
	logic [12:0] p;
	logic [6:0] cd[4];
	logic on[4];
	wire [1:0] digit_sel_r;
	wire [6:0] digit_code_r;
	wire digit_all_on_r, digit_enable_r, clear_busy_r;
	int fails = 0, check_count = 0, n;
	initial forever #5 clk_sys = ~clk_sys;
	fcd_host_model fcd_host_model_i(.clk(clk_sys), .pins(p));
	fcd_store_ctrl fcd_store_ctrl_i(.clk_sys, .rst_n, .select_low_first_n(p[12]), .select_low_second_n(p[11]),
		.write_strobe_n(p[10]), .mem_target_sel(p[9]), .loc_bit_high(p[8]), .loc_bit_low(p[7]),
		.data_in(p[6:0]), .wipe_chars_n, .cursor_view_sel, .dark_n, .digit_sel_r, .digit_code_r,
		.digit_all_on_r, .digit_enable_r, .clear_busy_r);
	task ck(input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask
	task summarize;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task til(input logic [2:0] v);
		n = 0;
		while ((v[2] ? clear_busy_r !== v[0] : digit_sel_r !== v[1:0]) && n < 12000) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 12000) fails++;
	endtask
	// Starting from position 3 makes every capture a fresh scan slot.
	task scan;
		til(3);
		for (int i = 0; i < 4; i++) begin
			til(i);
			repeat (3) @(negedge clk_sys);
			cd[i] = digit_code_r;
			on[i] = digit_all_on_r;
		end
	endtask
	// Four scans of up to two frames, dark and clear come to about 80000 clocks at worst.
	initial begin
		#900000 fails++;
		summarize;
	end
	initial begin
		repeat (8) @(negedge clk_sys);
		rst_n = 1;
		repeat (5) @(negedge clk_sys);
		for (int i = 0; i < 4; i++) fcd_host_model_i.wr(1, i, 7'h41 + i, 0);
		fcd_host_model_i.wr(1, 0, 7'h7f, 1);
		fcd_host_model_i.wr(0, 1, 7'h01, 0);
		scan;
		for (int i = 0; i < 4; i++) ck(cd[i], 7'h41 + i);
		$display("chars done");
		cursor_view_sel = 1;
		scan;
		for (int i = 0; i < 4; i++) ck(on[i], i == 1);
		ck(cd[0], 7'h41);
		fcd_host_model_i.wr(0, 1, 7'h7e, 0);
		$display("cursor done");
		dark_n = 0;
		wipe_chars_n = 0;
		repeat (6000) @(negedge clk_sys);
		ck(digit_enable_r, 0);
		ck(clear_busy_r, 0);
		wipe_chars_n = 1;
		repeat (4) @(negedge clk_sys);
		dark_n = 1;
		scan;
		for (int i = 0; i < 4; i++) ck({on[i], cd[i]}, 8'h41 + i);
		ck(digit_enable_r, 1);
		$display("dark done");
		fcd_host_model_i.wr(0, 2, 7'h01, 0);
		wipe_chars_n = 0;
		til(5);
		wipe_chars_n = 1;
		til(4);
		ck(n == `FCD_LOCS * `FCD_REFRESH_CYC, 1);
		scan;
		for (int i = 0; i < 4; i++) ck({on[i], cd[i]}, {i == 2, 7'h20});
		$display("clear done");
		summarize;
	end
endmodule // tb_top
